// *** hdl/dmcc_core.sv ***
// Direct-mode command interpreter: control commands, download and position events.
`timescale 1ns/10ps
`default_nettype none
module dmcc_core
    import dmcc_pkg::*;
(
    input wire logic sys_clk, // System clock, 50 MHz.
    input wire logic reset_n, // Asynchronous reset, active low.
    input wire logic cmd_valid, // Decoded frame present, one cycle.
    input wire logic [7:0] cmd_op, // Instruction number.
    input wire logic [7:0] cmd_type, // Type field.
    input wire logic [7:0] cmd_bank, // Motor/bank field.
    input wire logic [31:0] cmd_value, // Value field.
    input wire logic pos_reached, // Motor reached target, pulse.
    input wire logic prog_fetch, // Program engine took one instruction.
    input wire logic prog_wait, // Program engine wait flag.
    input wire logic [31:0] prog_accu, // Accumulator from program engine.
    input wire logic [31:0] prog_xreg, // X register from program engine.
    output logic rsp_valid, // Reply present, one cycle.
    output logic [7:0] rsp_status, // Reply status.
    output logic [7:0] rsp_cmd, // Reply command code.
    output logic [31:0] rsp_value, // Reply value.
    output logic rsp_special, // Reply uses special format.
    output logic exec_valid, // Non-control command to execute, pulse.
    output logic [CMD_W-1:0] exec_cmd, // Command to execute.
    output logic prog_run, // Program engine may run.
    output logic prog_load, // Load program counter, pulse.
    output logic [PM_AW-1:0] prog_load_addr, // New program counter.
    output logic prog_clear, // Clear accumulator, X, stack, flags, pulse.
    output logic factory_restore, // Restore nonvolatile defaults, pulse.
    output logic soft_reset_req, // Processor restart request, pulse.
    output logic download_mode // Download mode active.
);
    typedef enum logic [1:0] {DMCC_IDLE, DMCC_RUN, DMCC_STEP} dmcc_run_t;

    dmcc_pm_if pm ();
    dmcc_prog_mem u_mem (.sys_clk(sys_clk), .pm(pm));

    dmcc_run_t run_ff;
    logic dl_ff;
    logic [PM_AW-1:0] dl_addr_ff;
    logic [PM_AW-1:0] pc_ff;
    logic arm_once_ff;
    logic arm_all_ff;
    logic move_pending_ff;
    logic rd_pend_ff;
    logic is_ctrl;
    logic key_ok;
    logic [CMD_W-1:0] cmd_word;

    // Control commands are the 128..138 range plus 255; the bank field is not checked.
    assign is_ctrl = (cmd_op >= OP_STOP_APP && cmd_op <= OP_POS_REACHED) || cmd_op == OP_SOFT_RESET;
    assign key_ok = cmd_value == KEY_VALUE;
    assign cmd_word = {cmd_op, cmd_type, cmd_bank, cmd_value};

    // =====================================================
    // Download mode and program memory writes
    assign pm.wr_en = cmd_valid && dl_ff && !is_ctrl;
    assign pm.wr_addr = dl_addr_ff;
    assign pm.wr_data = cmd_word;
    assign pm.rd_addr = cmd_value[PM_AW-1:0];

    // Download flag and write pointer.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dl_ff <= 1'b0;
            dl_addr_ff <= RESET_ADDR;
        end
        else if (cmd_valid && cmd_op == OP_ENTER_DL)
        begin
            dl_ff <= 1'b1;
            dl_addr_ff <= cmd_value[PM_AW-1:0];
        end
        else if (cmd_valid && cmd_op == OP_EXIT_DL)
        begin
            dl_ff <= 1'b0;
        end
        else if (pm.wr_en)
        begin
            dl_addr_ff <= dl_addr_ff + 1'b1;
        end
    end

    // =====================================================
    // Program run state
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            run_ff <= DMCC_IDLE;
            pc_ff <= RESET_ADDR;
        end
        else
        begin
            if (cmd_valid && cmd_op == OP_STOP_APP)
            begin
                run_ff <= DMCC_IDLE;
            end
            else if (cmd_valid && cmd_op == OP_RUN_APP)
            begin
                run_ff <= DMCC_RUN;
                if (cmd_type == 8'h01)
                begin
                    pc_ff <= cmd_value[PM_AW-1:0];
                end
            end
            else if (cmd_valid && cmd_op == OP_STEP_APP)
            begin
                run_ff <= DMCC_STEP;
            end
            else if (cmd_valid && cmd_op == OP_RESET_APP)
            begin
                run_ff <= DMCC_IDLE;
                pc_ff <= RESET_ADDR;
            end
            else if (prog_fetch && run_ff != DMCC_IDLE)
            begin
                pc_ff <= pc_ff + 1'b1;
                if (run_ff == DMCC_STEP)
                begin
                    run_ff <= DMCC_IDLE;
                end
            end
        end
    end

    // Program engine control outputs; a step grants exactly one fetch.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prog_run <= 1'b0;
            prog_load <= 1'b0;
            prog_load_addr <= RESET_ADDR;
            prog_clear <= 1'b0;
            download_mode <= 1'b0;
        end
        else
        begin
            // Only run, step, stop and reset touch the run level, so a status query does not pause a program.
            if (cmd_valid && (cmd_op == OP_RUN_APP || cmd_op == OP_STEP_APP))
            begin
                prog_run <= 1'b1;
            end
            else if (cmd_valid && (cmd_op == OP_STOP_APP || cmd_op == OP_RESET_APP))
            begin
                prog_run <= 1'b0;
            end
            else
            begin
                prog_run <= (run_ff == DMCC_RUN) || (run_ff == DMCC_STEP && !prog_fetch);
            end
            prog_load <= cmd_valid && ((cmd_op == OP_RUN_APP && cmd_type == 8'h01) || cmd_op == OP_RESET_APP);
            prog_load_addr <= (cmd_op == OP_RESET_APP) ? RESET_ADDR : cmd_value[PM_AW-1:0];
            prog_clear <= cmd_valid && cmd_op == OP_RESET_APP;
            download_mode <= (cmd_valid && cmd_op == OP_ENTER_DL) ? 1'b1 :
                             (cmd_valid && cmd_op == OP_EXIT_DL) ? 1'b0 : dl_ff;
        end
    end

    // =====================================================
    // Position reached arming
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            arm_once_ff <= 1'b0;
            arm_all_ff <= 1'b0;
            move_pending_ff <= 1'b0;
        end
        else
        begin
            if (cmd_valid && cmd_op == OP_POS_REACHED)
            begin
                arm_once_ff <= (cmd_type == 8'h00);
                arm_all_ff <= (cmd_type == 8'h01);
            end
            else if (cmd_valid && !dl_ff && cmd_op == OP_MOVE_TO_POS && (arm_once_ff || arm_all_ff))
            begin
                move_pending_ff <= 1'b1;
                arm_once_ff <= 1'b0;
            end
            else if (pos_reached)
            begin
                move_pending_ff <= 1'b0;
            end
        end
    end

    // =====================================================
    // Replies and execution; a read reply waits one cycle for the memory.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rsp_valid <= 1'b0;
            rsp_status <= 8'h00;
            rsp_cmd <= 8'h00;
            rsp_value <= 32'h00000000;
            rsp_special <= 1'b0;
            exec_valid <= 1'b0;
            exec_cmd <= '0;
            factory_restore <= 1'b0;
            soft_reset_req <= 1'b0;
            rd_pend_ff <= 1'b0;
        end
        else
        begin
            rsp_valid <= 1'b0;
            rsp_special <= 1'b0;
            exec_valid <= 1'b0;
            factory_restore <= 1'b0;
            soft_reset_req <= 1'b0;
            rd_pend_ff <= 1'b0;
            exec_cmd <= cmd_word;
            rsp_status <= ST_OK;
            rsp_cmd <= cmd_op;
            rsp_value <= 32'h00000000;
            if (rd_pend_ff)
            begin
                rsp_valid <= 1'b1;
                rsp_special <= 1'b1;
                rsp_cmd <= OP_READ_MEM;
                rsp_value <= pm.rd_data[31:0];
            end
            else if (cmd_valid && is_ctrl)
            begin
                rsp_valid <= 1'b1;
                unique case (cmd_op)
                    OP_READ_MEM:
                    begin
                        rsp_valid <= 1'b0;
                        rd_pend_ff <= 1'b1;
                    end
                    OP_GET_STATUS:
                    begin
                        unique case (cmd_type)
                            8'h00: rsp_value <= {dl_ff ? MODE_DOWNLOAD : MODE_RUNNING, 7'h00, prog_wait,
                                                  8'h00, dl_addr_ff};
                            8'h01: rsp_value <= {run_ff == DMCC_IDLE ? MODE_STOPPED : MODE_RUNNING, 7'h00,
                                                  prog_wait, 8'h00, pc_ff};
                            8'h02: rsp_value <= prog_accu;
                            8'h03: rsp_value <= prog_xreg;
                            default: rsp_value <= 32'h00000000;
                        endcase
                    end
                    OP_GET_VERSION:
                    begin
                        rsp_value <= FW_VERSION;
                        rsp_special <= (cmd_type == 8'h00);
                    end
                    OP_FACTORY:
                    begin
                        rsp_valid <= 1'b0;
                        factory_restore <= key_ok;
                    end
                    OP_SOFT_RESET:
                    begin
                        soft_reset_req <= key_ok;
                    end
                    OP_POS_REACHED:
                    begin
                        rsp_value <= {24'h000000, cmd_value[7:0]};
                    end
                    default: rsp_value <= 32'h00000000;
                endcase
            end
            else if (cmd_valid && !dl_ff)
            begin
                exec_valid <= 1'b1;
            end
            else if (cmd_valid && dl_ff)
            begin
                rsp_valid <= 1'b1;
            end
            else if (pos_reached && move_pending_ff)
            begin
                rsp_valid <= 1'b1;
                rsp_status <= ST_POS_REACHED;
                rsp_cmd <= OP_POS_REACHED;
                rsp_value <= {24'h000000, MOTOR_MASK};
            end
        end
    end

    // =====================================================
    // Assertions
    // A frame right after a memory read is outside the contract, so some checks leave that cycle out.
    a_stop_idles: assert property (@(posedge sys_clk) disable iff (!reset_n)
        cmd_valid && cmd_op == OP_STOP_APP |=> run_ff == DMCC_IDLE) else $error("stop did not halt");
    a_run_starts: assert property (@(posedge sys_clk) disable iff (!reset_n)
        cmd_valid && cmd_op == OP_RUN_APP |=> prog_run) else $error("run did not start");
    a_step_once: assert property (@(posedge sys_clk) disable iff (!reset_n)
        run_ff == DMCC_STEP && prog_fetch && !cmd_valid |=> run_ff == DMCC_IDLE) else $error("step ran on");
    a_reset_clears: assert property (@(posedge sys_clk) disable iff (!reset_n)
        cmd_valid && cmd_op == OP_RESET_APP |=> pc_ff == RESET_ADDR ##0 (prog_clear && !prog_run))
        else $error("reset failed");
    a_dl_stores: assert property (@(posedge sys_clk) disable iff (!reset_n)
        cmd_valid && dl_ff && !is_ctrl && !rd_pend_ff |-> pm.wr_en ##1 (!exec_valid && rsp_valid))
        else $error("download executed");
    a_dl_exit: assert property (@(posedge sys_clk) disable iff (!reset_n)
        cmd_valid && cmd_op == OP_EXIT_DL |=> !dl_ff && !download_mode) else $error("download stuck");
    a_read_reply: assert property (@(posedge sys_clk) disable iff (!reset_n)
        cmd_valid && cmd_op == OP_READ_MEM |=> ##1 rsp_valid && rsp_special) else $error("no read reply");
    a_factory_quiet: assert property (@(posedge sys_clk) disable iff (!reset_n)
        cmd_valid && cmd_op == OP_FACTORY |=> !rsp_valid && factory_restore == $past(key_ok)) else $error("factory");
    a_soft_reset: assert property (@(posedge sys_clk) disable iff (!reset_n)
        soft_reset_req |-> $past(cmd_op) == OP_SOFT_RESET && $past(key_ok)) else $error("bad reset");
    a_event_reply: assert property (@(posedge sys_clk) disable iff (!reset_n)
        rsp_valid && rsp_status == ST_POS_REACHED |-> rsp_cmd == OP_POS_REACHED && rsp_value == 32'h00000001)
        else $error("bad event reply");
    a_once_clears: assert property (@(posedge sys_clk) disable iff (!reset_n)
        cmd_valid && !dl_ff && cmd_op == OP_MOVE_TO_POS && arm_once_ff |=> !arm_once_ff) else $error("once kept");
    a_all_keeps: assert property (@(posedge sys_clk) disable iff (!reset_n)
        arm_all_ff && !(cmd_valid && cmd_op == OP_POS_REACHED) |=> arm_all_ff) else $error("arm lost");
    a_ctrl_answered: assert property (@(posedge sys_clk) disable iff (!reset_n)
        cmd_valid && is_ctrl && !rd_pend_ff && cmd_op != OP_READ_MEM && cmd_op != OP_FACTORY
        |=> rsp_valid && rsp_cmd == $past(cmd_op)) else $error("control not answered");
    a_move_runs: assert property (@(posedge sys_clk) disable iff (!reset_n)
        cmd_valid && !is_ctrl && !dl_ff && !rd_pend_ff |=> exec_valid && !rsp_valid) else $error("command not run");
    // Cover the main scenarios so a run shows that each one was reached.
    c_event: cover property (@(posedge sys_clk) rsp_valid && rsp_status == ST_POS_REACHED);
    c_download: cover property (@(posedge sys_clk) pm.wr_en ##[1:20] rd_pend_ff);
    c_step: cover property (@(posedge sys_clk) run_ff == DMCC_STEP ##[1:20] run_ff == DMCC_IDLE);
    c_keyed_restore: cover property (@(posedge sys_clk) factory_restore);
    c_status_reply: cover property (@(posedge sys_clk) cmd_valid && cmd_op == OP_GET_STATUS ##1 rsp_valid);
endmodule
`default_nettype wire

// *** common/dmcc_pkg.sv ***
// Package with opcodes, status codes, field widths and reset values of the command interpreter.
package dmcc_pkg;
    // =====================================================
    // Opcodes
    localparam logic [7:0] OP_STOP_APP = 8'h80;
    localparam logic [7:0] OP_RUN_APP = 8'h81;
    localparam logic [7:0] OP_STEP_APP = 8'h82;
    localparam logic [7:0] OP_RESET_APP = 8'h83;
    localparam logic [7:0] OP_ENTER_DL = 8'h84;
    localparam logic [7:0] OP_EXIT_DL = 8'h85;
    localparam logic [7:0] OP_READ_MEM = 8'h86;
    localparam logic [7:0] OP_GET_STATUS = 8'h87;
    localparam logic [7:0] OP_GET_VERSION = 8'h88;
    localparam logic [7:0] OP_FACTORY = 8'h89;
    localparam logic [7:0] OP_POS_REACHED = 8'h8A;
    localparam logic [7:0] OP_SOFT_RESET = 8'hFF;
    localparam logic [7:0] OP_MOVE_TO_POS = 8'h04;
    // =====================================================
    // Status codes and magic values
    localparam logic [7:0] ST_OK = 8'h64;
    localparam logic [7:0] ST_POS_REACHED = 8'h80;
    localparam logic [31:0] KEY_VALUE = 32'h000004D2;
    localparam logic [7:0] MOTOR_MASK = 8'h01;
    // =====================================================
    // Program memory, version and status modes
    localparam int PM_AW = 8;
    localparam int PM_DEPTH = 256;
    localparam logic [31:0] FW_VERSION = 32'h00010000; // Arbitrary value.
    localparam logic [7:0] MODE_STOPPED = 8'h00;
    localparam logic [7:0] MODE_RUNNING = 8'h01;
    localparam logic [7:0] MODE_STEP = 8'h02;
    localparam logic [7:0] MODE_DOWNLOAD = 8'h03;
    localparam logic [PM_AW-1:0] RESET_ADDR = 8'h00;
    // Command word layout stored in program memory: opcode, type, bank, value.
    localparam int CMD_W = 56;
endpackage

// *** common/dmcc_pm_if.sv ***
// Interface carrying program memory write and read between interpreter and memory.
`timescale 1ns/10ps
`default_nettype none
interface dmcc_pm_if;
    import dmcc_pkg::*;
    logic wr_en;
    logic [PM_AW-1:0] wr_addr;
    logic [CMD_W-1:0] wr_data;
    logic [PM_AW-1:0] rd_addr;
    logic [CMD_W-1:0] rd_data;
    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// *** hdl/dmcc_prog_mem.sv ***
// Program memory holding downloaded commands, one registered read port.
`timescale 1ns/10ps
`default_nettype none
module dmcc_prog_mem
    import dmcc_pkg::*;
(
    input wire logic sys_clk, // System clock.
    dmcc_pm_if.mem pm // Memory port.
);
    logic [CMD_W-1:0] mem_q [PM_DEPTH];

    // The array has no reset so it maps onto block memory.
    always_ff @(posedge sys_clk)
    begin
        if (pm.wr_en)
        begin
            mem_q[pm.wr_addr] <= pm.wr_data;
        end
        pm.rd_data <= mem_q[pm.rd_addr];
    end
endmodule
`default_nettype wire

// *** test/dmcc_host_model.sv ***
// Host model that sends decoded command frames into the command interpreter.
`timescale 1ns/10ps
`default_nettype none
module dmcc_host_model
    import dmcc_pkg::*;
(
    input wire logic sys_clk, // System clock.
    output var logic cmd_valid, // Frame strobe, one cycle.
    output var logic [7:0] cmd_op, // Instruction number.
    output var logic [7:0] cmd_type, // Type field.
    output var logic [7:0] cmd_bank, // Motor/bank field.
    output var logic [31:0] cmd_value // Value field.
);
    // =====================================================
    // Frame driver
    // Fields start idle; the strobe is low so nothing is taken before the first frame.
    initial
    begin
        cmd_valid = 1'b0;
        cmd_op = 8'h00;
        cmd_type = 8'h00;
        cmd_bank = 8'h00;
        cmd_value = 32'h00000000;
    end

    // One frame: raised just after an edge, held through the taking edge, then released.
    // Released fields show inverted junk so a design sampling outside the strobe goes wrong.
    task automatic send(input logic [7:0] op, input logic [7:0] typ, input logic [31:0] val);
        @(posedge sys_clk);
        #1;
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_type = typ;
        cmd_bank = 8'h00;
        cmd_value = val;
        @(posedge sys_clk);
        #1;
        cmd_valid = 1'b0;
        cmd_op = ~op;
        cmd_type = ~typ;
        cmd_bank = 8'hFF;
        cmd_value = ~val;
    endtask

    // The position request is only ever sent as a direct frame, with the single motor bit set.
    task automatic pos_request(input logic [7:0] typ);
        send(OP_POS_REACHED, typ, {24'h000000, MOTOR_MASK});
    endtask

    // Restore and restart sent here carry the key; the restart reply is not relied upon.
    task automatic send_keyed(input logic [7:0] op);
        send(op, 8'h00, KEY_VALUE);
    endtask
endmodule
`default_nettype wire

// *** test/test_direct_mode_control_commands.sv ***
// Self-checking testbench of the direct-mode command interpreter.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp, msg) begin n_compared++; if ((got) !== (exp)) begin bad_count++; \
    $display("Error at %0t: %s", $time, msg); end end
module test_direct_mode_control_commands;
    import dmcc_pkg::*;
    logic sys_clk, reset_n, pos_reached, prog_fetch, prog_wait;
    logic [31:0] prog_accu, prog_xreg;
    wire logic cmd_valid, rsp_valid, rsp_special, exec_valid, prog_run, prog_load, prog_clear;
    wire logic factory_restore, soft_reset_req, download_mode;
    wire logic [7:0] cmd_op, cmd_type, cmd_bank, rsp_status, rsp_cmd, prog_load_addr;
    wire logic [31:0] cmd_value, rsp_value;
    wire logic [CMD_W-1:0] exec_cmd;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;

    // =====================================================
    // Design and host
    dmcc_host_model host (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_type(cmd_type),
        .cmd_bank(cmd_bank), .cmd_value(cmd_value));
    dmcc_core dut (.sys_clk(sys_clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_type(cmd_type), .cmd_bank(cmd_bank), .cmd_value(cmd_value), .pos_reached(pos_reached),
        .prog_fetch(prog_fetch), .prog_wait(prog_wait), .prog_accu(prog_accu), .prog_xreg(prog_xreg),
        .rsp_valid(rsp_valid), .rsp_status(rsp_status), .rsp_cmd(rsp_cmd), .rsp_value(rsp_value),
        .rsp_special(rsp_special), .exec_valid(exec_valid), .exec_cmd(exec_cmd), .prog_run(prog_run),
        .prog_load(prog_load), .prog_load_addr(prog_load_addr), .prog_clear(prog_clear),
        .factory_restore(factory_restore), .soft_reset_req(soft_reset_req), .download_mode(download_mode));

    // =====================================================
    // Clock and hang guard
    // The run takes under a hundred cycles, so a ceiling of 3000 only trips on a real hang.
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            bad_count++;
            $display("Error at %0t: run did not finish in time", $time);
            report_and_stop();
        end
    end

    // =====================================================
    // Shared tasks
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // Replies are registered, so they are visible just after the edge that took the frame.
    task automatic rsp_is(input logic [7:0] st, input logic [7:0] op, input logic [31:0] val);
        `CHK(rsp_valid, 1'b1, "reply missing")
        `CHK(rsp_status, st, "reply status")
        `CHK(rsp_cmd, op, "reply command")
        `CHK(rsp_value, val, "reply value")
    endtask

    task automatic pulse_pos();
        idle(0);
        @(posedge sys_clk);
        #1;
        pos_reached = 1'b1;
        idle(1);
        pos_reached = 1'b0;
    endtask

    task automatic move(input logic [31:0] val);
        host.send(OP_MOVE_TO_POS, 8'h00, val);
        `CHK(exec_valid, 1'b1, "move not executed")
        `CHK(exec_cmd, {OP_MOVE_TO_POS, 8'h00, 8'h00, val}, "move word")
        `CHK(rsp_valid, 1'b0, "move replied")
    endtask

    // =====================================================
    // Scenarios
    task automatic t_event_once();
        host.pos_request(8'h00);
        rsp_is(ST_OK, OP_POS_REACHED, 32'h00000001);
        move(32'h00000100);
        pulse_pos();
        rsp_is(ST_POS_REACHED, OP_POS_REACHED, 32'h00000001);
        move(32'h00000200);
        pulse_pos();
        `CHK(rsp_valid, 1'b0, "second move gave event")
        $display("test event_once done");
    endtask

    task automatic t_event_every();
        host.pos_request(8'h01);
        rsp_is(ST_OK, OP_POS_REACHED, 32'h00000001);
        for (int i = 0; i < 2; i++)
        begin
            move(32'h00000300 + i);
            pulse_pos();
            rsp_is(ST_POS_REACHED, OP_POS_REACHED, 32'h00000001);
        end
        $display("test event_every done");
    endtask

    task automatic t_program();
        host.send(OP_RUN_APP, 8'h01, 32'h00000005);
        `CHK({prog_run, prog_load, prog_load_addr}, {2'b11, 8'h05}, "run from address")
        `CHK(rsp_status, ST_OK, "run reply")
        host.send(OP_GET_STATUS, 8'h01, 32'h00000000);
        rsp_is(ST_OK, OP_GET_STATUS, {MODE_RUNNING, 7'h00, 1'b1, 8'h00, 8'h05});
        `CHK(prog_run, 1'b1, "status query paused program")
        host.send(OP_STOP_APP, 8'h00, 32'h00000000);
        `CHK(prog_run, 1'b0, "stop")
        host.send(OP_RUN_APP, 8'h00, 32'h00000000);
        `CHK({prog_run, prog_load}, 2'b10, "continue")
        host.send(OP_RESET_APP, 8'h00, 32'h00000000);
        `CHK({prog_run, prog_clear}, 2'b01, "reset program")
        host.send(OP_STEP_APP, 8'h00, 32'h00000000);
        idle(3);
        `CHK(prog_run, 1'b1, "step waits for fetch")
        prog_fetch = 1'b1;
        idle(1);
        prog_fetch = 1'b0;
        idle(1);
        `CHK(prog_run, 1'b0, "step stops after one")
        $display("test program done");
    endtask

    task automatic t_download();
        host.send(OP_ENTER_DL, 8'h00, 32'h00000010);
        `CHK(download_mode, 1'b1, "enter download")
        host.send(OP_MOVE_TO_POS, 8'h00, 32'h00001234);
        `CHK({exec_valid, rsp_valid, rsp_status}, {2'b01, ST_OK}, "stored not run")
        host.send(OP_GET_STATUS, 8'h00, 32'h00000000);
        rsp_is(ST_OK, OP_GET_STATUS, {MODE_DOWNLOAD, 7'h00, 1'b1, 8'h00, 8'h11});
        host.send(OP_READ_MEM, 8'h00, 32'h00000010);
        idle(1);
        `CHK({rsp_valid, rsp_special, rsp_value}, {2'b11, 32'h00001234}, "memory read")
        host.send(OP_EXIT_DL, 8'h00, 32'h00000000);
        `CHK(download_mode, 1'b0, "exit download")
        move(32'h00000022);
        $display("test download done");
    endtask

    task automatic t_status();
        host.send(OP_GET_STATUS, 8'h02, 32'h00000000);
        `CHK(rsp_value, 32'hA5A50001, "accumulator")
        host.send(OP_GET_STATUS, 8'h03, 32'h00000000);
        `CHK(rsp_value, 32'h00005A5A, "x register")
        host.send(OP_GET_STATUS, 8'h01, 32'h00000000);
        `CHK(rsp_value[31:8], {MODE_STOPPED, 7'h00, 1'b1, 8'h00}, "mode and wait")
        host.send(OP_GET_VERSION, 8'h01, 32'h00000000);
        `CHK({rsp_special, rsp_value}, {1'b0, FW_VERSION}, "binary version")
        host.send(OP_GET_VERSION, 8'h00, 32'h00000000);
        `CHK({rsp_valid, rsp_special}, 2'b11, "string version")
        $display("test status done");
    endtask

    task automatic t_keys();
        host.send(OP_FACTORY, 8'h00, 32'h000004D3);
        `CHK({factory_restore, rsp_valid}, 2'b00, "restore without key")
        host.send_keyed(OP_FACTORY);
        `CHK({factory_restore, rsp_valid}, 2'b10, "restore with key")
        host.send(OP_SOFT_RESET, 8'h00, 32'h00000000);
        `CHK(soft_reset_req, 1'b0, "restart without key")
        host.send_keyed(OP_SOFT_RESET);
        `CHK(soft_reset_req, 1'b1, "restart with key")
        $display("test keys done");
    endtask

    // =====================================================
    // Closing and main sequence
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Reset for 20 cycles with every input defined, then run the scenarios in turn.
    initial
    begin
        reset_n = 1'b0;
        pos_reached = 1'b0;
        prog_fetch = 1'b0;
        prog_wait = 1'b1;
        prog_accu = 32'hA5A50001;
        prog_xreg = 32'h00005A5A;
        repeat (20) @(posedge sys_clk);
        #1;
        reset_n = 1'b1;
        t_event_once();
        t_event_every();
        t_program();
        t_download();
        t_status();
        t_keys();
        report_and_stop();
    end
endmodule
`default_nettype wire
